// [verilog/pmsc_cmd_port.sv]
// Purpose: slave command port holding config word and measurement register
// Assumes: measurement source gives a valid strobe with a 10-bit value
// Notes: sda is open drain; sda_oe_out high pulls the line low
`timescale 1ns/1ps
`default_nettype none
module pmsc_cmd_port #(
    parameter logic [6:0] SLAVE_ADDR = pmsc_pkg::PMSC_ADDR_DEFAULT
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic meas_valid_in,
    input wire logic [9:0] meas_value_in,
    input wire logic [1:0] meas_kind_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [15:0] config_out,
    output logic [15:0] meas_out
);
    pmsc_pkg::pmsc_line_s line;
    pmsc_pkg::pmsc_state_e state_r, state_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [1:0] bytecnt_r, bytecnt_nxt;
    logic rd_r, rd_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [7:0] cfg_lo_r, cfg_lo_nxt;
    logic [15:0] meas_r, meas_nxt;
    logic [15:0] snap_r, snap_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] rx_byte;
    logic [15:0] tx_word;

    pmsc_line_sync u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .line_out(line)
    );

    assign rx_byte = {shift_r[6:0], line.sda};
    // Config reads return the config word, measurement reads the snapshot;
    // unknown codes fall back to the snapshot rather than a made-up value
    always_comb begin
        case (cmd_r)
            pmsc_pkg::PMSC_CONFIG_WORD_CMD: tx_word = cfg_r;
            pmsc_pkg::PMSC_VOLTAGE_READ_CMD: tx_word = snap_r;
            pmsc_pkg::PMSC_CURRENT_READ_CMD: tx_word = snap_r;
            pmsc_pkg::PMSC_POWER_READ_CMD: tx_word = snap_r;
            default: tx_word = snap_r;
        endcase
    end

    // Measurement register: only results matching the live selection land,
    // so pending results of the old kind are dropped as soon as the config changes
    always_comb begin
        meas_nxt = meas_r;
        if (meas_valid_in && meas_kind_in ==
            cfg_r[pmsc_pkg::PMSC_SEL_HI:pmsc_pkg::PMSC_SEL_LO]) begin
            meas_nxt = {meas_value_in,
                {pmsc_pkg::PMSC_PAD_BITS{1'b0}}};
        end
    end

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        bitcnt_nxt = bitcnt_r;
        cmd_nxt = cmd_r;
        bytecnt_nxt = bytecnt_r;
        rd_nxt = rd_r;
        cfg_nxt = cfg_r;
        cfg_lo_nxt = cfg_lo_r;
        snap_nxt = snap_r;
        oe_nxt = oe_r;
        if (line.stop) begin
            state_nxt = pmsc_pkg::PMSC_IDLE;
            oe_nxt = 1'b0;
        end else if (line.start) begin
            state_nxt = pmsc_pkg::PMSC_ADDR;
            bitcnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else begin
            case (state_r)
                pmsc_pkg::PMSC_IDLE: begin
                    oe_nxt = 1'b0;
                end
                pmsc_pkg::PMSC_ADDR, pmsc_pkg::PMSC_RX: begin
                    if (line.scl_rise) begin
                        shift_nxt = rx_byte;
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end
                    if (line.scl_fall && bitcnt_r == 4'h8) begin
                        bitcnt_nxt = 4'h0;
                        if (state_r == pmsc_pkg::PMSC_ADDR) begin
                            if (shift_r[7:1] == SLAVE_ADDR) begin
                                rd_nxt = shift_r[0];
                                oe_nxt = 1'b1;
                                bytecnt_nxt = 2'h0;
                                state_nxt = pmsc_pkg::PMSC_ADDR_ACK;
                                // Whole-word capture at read start
                                if (shift_r[0]) begin
                                    snap_nxt = meas_r;
                                end
                            end else begin
                                state_nxt = pmsc_pkg::PMSC_WAIT;
                            end
                        end else begin
                            oe_nxt = 1'b1;
                            state_nxt = pmsc_pkg::PMSC_RX_ACK;
                            if (bytecnt_r == 2'h0) begin
                                cmd_nxt = shift_r;
                            end else if (bytecnt_r == 2'h1) begin
                                cfg_lo_nxt = shift_r;
                            end else if (bytecnt_r == 2'h2 &&
                                cmd_r == pmsc_pkg::PMSC_CONFIG_WORD_CMD) begin
                                cfg_nxt = {shift_r, cfg_lo_r};
                            end
                            if (bytecnt_r != 2'h3) begin
                                bytecnt_nxt = bytecnt_r + 2'h1;
                            end
                        end
                    end
                end
                pmsc_pkg::PMSC_ADDR_ACK, pmsc_pkg::PMSC_RX_ACK: begin
                    if (line.scl_fall) begin
                        if (rd_r && state_r == pmsc_pkg::PMSC_ADDR_ACK) begin
                            // Low byte first
                            shift_nxt = tx_word[7:0];
                            oe_nxt = ~tx_word[7];
                            state_nxt = pmsc_pkg::PMSC_TX;
                        end else begin
                            oe_nxt = 1'b0;
                            state_nxt = pmsc_pkg::PMSC_RX;
                        end
                    end
                end
                pmsc_pkg::PMSC_TX: begin
                    if (line.scl_fall) begin
                        if (bitcnt_r == pmsc_pkg::PMSC_BIT_LAST) begin
                            bitcnt_nxt = 4'h0;
                            oe_nxt = 1'b0;
                            state_nxt = pmsc_pkg::PMSC_TX_ACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt = ~shift_r[6];
                            bitcnt_nxt = bitcnt_r + 4'h1;
                        end
                    end
                end
                pmsc_pkg::PMSC_TX_ACK: begin
                    if (line.scl_rise) begin
                        // Master nack ends the read
                        if (line.sda || bytecnt_r != 2'h0) begin
                            state_nxt = pmsc_pkg::PMSC_WAIT;
                        end else begin
                            bytecnt_nxt = 2'h1;
                            shift_nxt = tx_word[15:8];
                        end
                    end
                    if (line.scl_fall && state_r == pmsc_pkg::PMSC_TX_ACK &&
                        bytecnt_r == 2'h1) begin
                        oe_nxt = ~shift_r[7];
                        state_nxt = pmsc_pkg::PMSC_TX;
                    end
                end
                pmsc_pkg::PMSC_WAIT: begin
                    oe_nxt = 1'b0;
                end
                default: begin
                    state_nxt = pmsc_pkg::PMSC_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_r <= pmsc_pkg::PMSC_IDLE;
            shift_r <= 8'h00;
            bitcnt_r <= 4'h0;
            cmd_r <= 8'h00;
            bytecnt_r <= 2'h0;
            rd_r <= 1'b0;
            cfg_r <= pmsc_pkg::PMSC_CONFIG_RESET;
            cfg_lo_r <= 8'h00;
            meas_r <= pmsc_pkg::PMSC_MEAS_RESET;
            snap_r <= pmsc_pkg::PMSC_MEAS_RESET;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            bitcnt_r <= bitcnt_nxt;
            cmd_r <= cmd_nxt;
            bytecnt_r <= bytecnt_nxt;
            rd_r <= rd_nxt;
            cfg_r <= cfg_nxt;
            cfg_lo_r <= cfg_lo_nxt;
            meas_r <= meas_nxt;
            snap_r <= snap_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_r;
    assign config_out = cfg_r;
    assign meas_out = meas_r;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_pad_zero: assert property (meas_r[5:0] == 6'h00)
        else $error("pad bits not zero");
    a_snap_zero: assert property (snap_r[5:0] == 6'h00)
        else $error("snapshot pad not zero");
    a_meas_kind: assert property (meas_valid_in &&
        meas_kind_in != cfg_r[7:6] |=> $stable(meas_r))
        else $error("wrong kind loaded");
    a_meas_load: assert property (meas_valid_in &&
        meas_kind_in == cfg_r[7:6]
        |=> meas_r == {$past(meas_value_in), 6'h00})
        else $error("measurement not loaded");
    a_snap_hold: assert property (state_r == pmsc_pkg::PMSC_TX
        |=> $stable(snap_r)) else $error("snapshot moved mid read");
    a_cfg_write: assert property ($changed(cfg_r)
        |-> $past(state_r) == pmsc_pkg::PMSC_RX
        && $past(cmd_r) == pmsc_pkg::PMSC_CONFIG_WORD_CMD)
        else $error("config changed without write");
    a_ack_drive: assert property (state_r == pmsc_pkg::PMSC_RX_ACK
        |-> oe_r) else $error("no ack on byte");
    a_rx_release: assert property (state_r == pmsc_pkg::PMSC_RX
        || state_r == pmsc_pkg::PMSC_IDLE |-> !oe_r)
        else $error("sda driven while receiving");
    c_cfg_write: cover property ($changed(cfg_r));
    c_read_tx: cover property (state_r == pmsc_pkg::PMSC_TX_ACK &&
        bytecnt_r == 2'h1);
    c_meas_load: cover property (meas_valid_in && meas_kind_in == cfg_r[7:6]);
endmodule
`default_nettype wire

// [verilog/pmsc_pkg.sv]
// Purpose: constants and types for the power monitor two-wire command port
// Assumes: 125 MHz system clock, bus clock sampled as plain input
// Notes: slave address is a parameter of the top module
//
// Function
// - Result is 16-bit two's complement: +FS 4000h, -FS C000h, zero 0000h.
// - Bit 15 is sign, nine magnitude bits follow, point over low six bits.
// - The six low bits of every returned measurement word are zero.
// - One measurement register holds only the quantity last selected.
// - All three measurement read commands return the same register.
// - Direction bit is 0 for write, 1 for read; ack is 0, nack is 1.
// - A config write is address, command, low byte, high byte, each acked.
// - Config read: D0h, repeated start, low byte acked, high byte nacked.
// - Voltage read command is 8Bh, valid when the select field is 01.
// - Current read command is 8Ch, valid when the select field is 10.
// - Power read command is 96h, valid when the select field is 00.
// - Select field in bits 7:6 picks 00 power, 01 voltage, 10 current.
// - A config change shows in the result only after pending work ends; the code drops results of the old kind as soon as cfg_r changes.
package pmsc_pkg;
    localparam logic [7:0] PMSC_CONFIG_WORD_CMD = 8'hD0;
    localparam logic [7:0] PMSC_VOLTAGE_READ_CMD = 8'h8B;
    localparam logic [7:0] PMSC_CURRENT_READ_CMD = 8'h8C;
    localparam logic [7:0] PMSC_POWER_READ_CMD = 8'h96;
    localparam logic [15:0] PMSC_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] PMSC_MEAS_RESET = 16'h0000;
    localparam int PMSC_SEL_HI = 7;
    localparam int PMSC_SEL_LO = 6;
    localparam int PMSC_PAD_BITS = 6;
    localparam logic [1:0] PMSC_SEL_POWER = 2'h0;
    localparam logic [1:0] PMSC_SEL_VOLTAGE = 2'h1;
    localparam logic [1:0] PMSC_SEL_CURRENT = 2'h2;
    localparam logic [3:0] PMSC_BIT_LAST = 4'h7;
    localparam logic [6:0] PMSC_ADDR_DEFAULT = 7'h40;

    typedef enum logic [3:0] {
        PMSC_IDLE = 4'b0000,
        PMSC_ADDR = 4'b0001,
        PMSC_ADDR_ACK = 4'b0010,
        PMSC_RX = 4'b0011,
        PMSC_RX_ACK = 4'b0100,
        PMSC_TX = 4'b0101,
        PMSC_TX_ACK = 4'b0110,
        PMSC_WAIT = 4'b0111
    } pmsc_state_e;

    // Sampled two-wire line condition
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
        logic scl;
    } pmsc_line_s;
endpackage

// [verilog/pmsc_line_sync.sv]
// Purpose: synchronise the bus pins and find edges and start/stop
// Assumes: pins are asynchronous to clk_in
// Notes: first flops feed only the second flops
`timescale 1ns/1ps
`default_nettype none
module pmsc_line_sync (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output var pmsc_pkg::pmsc_line_s line_out
);
    logic [1:0] scl_s_r, scl_s_nxt;
    logic [1:0] sda_s_r, sda_s_nxt;
    logic scl_d_r, scl_d_nxt;
    logic sda_d_r, sda_d_nxt;

    always_comb begin
        scl_s_nxt = {scl_s_r[0], scl_in};
        sda_s_nxt = {sda_s_r[0], sda_in};
        scl_d_nxt = scl_s_r[1];
        sda_d_nxt = sda_s_r[1];
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= scl_s_nxt;
            sda_s_r <= sda_s_nxt;
            scl_d_r <= scl_d_nxt;
            sda_d_r <= sda_d_nxt;
        end
    end

    always_comb begin
        line_out.scl = scl_d_r;
        line_out.sda = sda_d_r;
        line_out.scl_rise = scl_s_r[1] & ~scl_d_r;
        line_out.scl_fall = ~scl_s_r[1] & scl_d_r;
        line_out.start = scl_d_r & scl_s_r[1] & sda_d_r & ~sda_s_r[1];
        line_out.stop = scl_d_r & scl_s_r[1] & ~sda_d_r & sda_s_r[1];
    end
endmodule
`default_nettype wire

// [test/pmsc_host_model.sv]
// Purpose: two-wire bus master model driving the command port
// Assumes: SDA has a pull-up; 64 ns bus clock period, 32 ns per phase
// Notes: SCL stands high between frames; never issues reserved codes
`timescale 1ns/1ps
`default_nettype none
module pmsc_host_model (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // Sample mid high phase, well after the synchroniser delay
    task automatic bit_io(input logic b, output logic s);
        sda_low_out = ~b;
        #16 scl_out = 1'b1;
        #16 s = sda_in;
        #16 scl_out = 1'b0;
        #16;
    endtask

    // Start and repeated start alike
    task automatic cond_start();
        sda_low_out = 1'b0;
        #16 scl_out = 1'b1;
        #16 sda_low_out = 1'b1;
        #16 scl_out = 1'b0;
        #16;
    endtask

    task automatic cond_stop();
        sda_low_out = 1'b1;
        #16 scl_out = 1'b1;
        #16 sda_low_out = 1'b0;
        #32;
    endtask

    // Ninth bit: ack_b 0 is ack, 1 is nack or release
    task automatic byte_io(input logic [7:0] b, input logic ack_b,
                           output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(ack_b, ack);
    endtask

    task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                              input logic [15:0] w, output logic [3:0] acks);
        logic [7:0] r;
        cond_start();
        byte_io({a, 1'b0}, 1'b1, r, acks[3]);
        byte_io(c, 1'b1, r, acks[2]);
        byte_io(w[7:0], 1'b1, r, acks[1]);
        byte_io(w[15:8], 1'b1, r, acks[0]);
        cond_stop();
    endtask

    task automatic read_word(input logic [6:0] a, input logic [7:0] c,
                             output logic [15:0] w, output logic [2:0] acks);
        logic [7:0] r;
        logic a0;
        cond_start();
        byte_io({a, 1'b0}, 1'b1, r, acks[2]);
        byte_io(c, 1'b1, r, acks[1]);
        cond_start();
        byte_io({a, 1'b1}, 1'b1, r, acks[0]);
        byte_io(8'hFF, 1'b0, w[7:0], a0);
        byte_io(8'hFF, 1'b1, w[15:8], a0);
        cond_stop();
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Purpose: self-checking bench for the command port
// Assumes: host model drives the bus, bench drives measurement inputs
// Notes: ordinary cases are table rows, awkward ones follow by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [6:0] ADDR = pmsc_pkg::PMSC_ADDR_DEFAULT;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] cmd;
        logic [9:0] val;
        logic [15:0] exp;
    } pmsc_row_s;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic meas_valid_in = 1'b0;
    logic [9:0] meas_value_in = 10'h000;
    logic [1:0] meas_kind_in = 2'h0;
    wire logic scl, host_low, sda_out, sda_oe_out;
    wire logic [15:0] config_out, meas_out;
    // Open drain with pull-up: low if anyone pulls
    wire logic sda = ~(host_low | (sda_oe_out & ~sda_out));
    int n_mismatch = 0;
    int n_compared = 0;
    logic [15:0] w, rd;
    logic [3:0] a4;
    logic [2:0] a3;
    pmsc_row_s rows [6] = '{
        '{pmsc_pkg::PMSC_SEL_POWER, 8'h96, 10'h100, 16'h4000},
        '{pmsc_pkg::PMSC_SEL_VOLTAGE, 8'h8B, 10'h000, 16'h0000},
        '{pmsc_pkg::PMSC_SEL_CURRENT, 8'h8C, 10'h300, 16'hC000},
        '{pmsc_pkg::PMSC_SEL_CURRENT, 8'h96, 10'h1FF, 16'h7FC0},
        '{pmsc_pkg::PMSC_SEL_VOLTAGE, 8'h8C, 10'h2AB, 16'hAAC0},
        '{pmsc_pkg::PMSC_SEL_POWER, 8'h8B, 10'h155, 16'h5540}};

    always #4 clk_in = ~clk_in;

    pmsc_cmd_port #(.SLAVE_ADDR(ADDR)) dut (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
        .meas_valid_in(meas_valid_in), .meas_value_in(meas_value_in),
        .meas_kind_in(meas_kind_in), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .config_out(config_out),
        .meas_out(meas_out));
    pmsc_host_model host (.scl_out(scl), .sda_low_out(host_low),
        .sda_in(sda));

    task automatic chk_word(input string nm, input logic [15:0] e,
                            input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_ack(input string nm, input logic [3:0] e,
                           input logic [3:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic meas(input logic [1:0] k, input logic [9:0] v);
        @(posedge clk_in) #1;
        meas_valid_in = 1'b1;
        meas_kind_in = k;
        meas_value_in = v;
        @(posedge clk_in) #1;
        meas_valid_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk_in) #1;
        reset_n_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1 reset_n_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #1;
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        close_out();
    end

    initial begin
        do_reset();
        chk_word("config reset", 16'h0000, config_out);
        chk_word("meas reset", 16'h0000, meas_out);
        chk_ack("oe idle", 4'h0, {3'h0, sda_oe_out});
        chk_ack("sda level", 4'h0, {3'h0, sda_out});
        foreach (rows[i]) begin
            w = {8'hA5, rows[i].sel, 6'h2A};
            host.write_word(ADDR, pmsc_pkg::PMSC_CONFIG_WORD_CMD,
                w, a4);
            chk_ack("write acks", 4'h0, a4);
            chk_word("config", w, config_out);
            meas(rows[i].sel, rows[i].val);
            chk_word("meas_out", rows[i].exp, meas_out);
            host.read_word(ADDR, rows[i].cmd, rd, a3);
            chk_ack("read acks", 4'h0, {1'b0, a3});
            chk_word("meas read", rows[i].exp, rd);
            chk_word("pad bits", 16'h0000, {10'h000, rd[5:0]});
            host.read_word(ADDR, pmsc_pkg::PMSC_CONFIG_WORD_CMD, rd, a3);
            chk_ack("cfg read acks", 4'h0, {1'b0, a3});
            chk_word("config read", w, rd);
        end
        // Result of another quantity must not load
        meas(pmsc_pkg::PMSC_SEL_VOLTAGE, 10'h0AA);
        chk_word("kind mismatch", 16'h5540, meas_out);
        host.write_word(ADDR ^ 7'h01, 8'hD0, 16'hFFFF, a4);
        chk_ack("other addr", 4'hF, a4);
        chk_word("config kept", w, config_out);
        host.write_word(ADDR, 8'h8B, 16'h1234, a4);
        chk_ack("non config acks", 4'h0, a4);
        chk_word("non config write", w, config_out);
        // New result lands late in low byte, during its eighth data bit; both bytes stay old
        fork
            host.read_word(ADDR, 8'h96, rd, a3);
            begin
                #2300;
                meas(pmsc_pkg::PMSC_SEL_POWER, 10'h3FF);
            end
        join
        chk_word("snapshot", 16'h5540, rd);
        chk_word("new meas", 16'hFFC0, meas_out);
        do_reset();
        chk_word("config rereset", 16'h0000, config_out);
        close_out();
    end
endmodule
`default_nettype wire
